// [testbench/dccfg_station.sv]
// command station model issuing programming commands and timing the ack
`timescale 1ns/1ps
module dccfg_station (
  // clock and status from the decoder
  input wire logic clk,
  input wire logic busy,
  input wire logic done,
  input wire logic reject,
  input wire logic ack,
  // command towards the decoder
  output logic valid,
  output dccfg_pkg::dccfg_mode_e mode,
  output logic write,
  output logic [dccfg_pkg::ADDR_W-1:0] addr,
  output logic [dccfg_pkg::CV_W-1:0] cv,
  output logic [7:0] data
);
  import dccfg_pkg::*;
  logic got_done;
  logic got_rej;
  int ack_len;
  int tmo;
  initial begin
    valid = 1'b0;
    mode = MD_DIRECT;
    write = 1'b0;
    addr = 14'h0003;
    cv = 10'h000;
    data = 8'h00;
    tmo = 0;
  end
  task automatic send(input dccfg_mode_e m, input logic w,
                      input logic [CV_W-1:0] n, input logic [7:0] d);
    int i;
    got_done = 1'b0;
    got_rej = 1'b0;
    ack_len = 0;
    @(negedge clk);
    for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk);
    if (busy !== 1'b0) tmo++;
    mode = m;
    write = w;
    cv = n;
    data = d;
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    // released lines show a changed value so a late sample cannot match
    cv = ~n;
    data = ~d;
    for (i = 0; i < 8 && done !== 1'b1 && reject !== 1'b1; i++)
      @(negedge clk);
    got_done = (done === 1'b1);
    got_rej = (reject === 1'b1);
    if (!got_done && !got_rej) tmo++;
    // the load pulse is timed in whole cycles while it stands
    for (i = 0; i < 100 && ack === 1'b1; i++) begin
      ack_len++;
      @(negedge clk);
    end
  endtask
endmodule

// [testbench/decoder_config_programming_tb.sv]
// self-checking bench: factory image, programming modes, function keys
`timescale 1ns/1ps
module decoder_config_programming_tb;
  import dccfg_pkg::*;
  logic clk, srst, fv, fon, fwd, cam;
  logic [3:0] fid;
  logic [13:0] fa, aa, ca;
  logic [9:0] cc;
  logic [7:0] cd, rd, vs, ac, br, cac, cbr, cons, vol, bg;
  logic cvl, cw, busy, done, rej, ack, hl, bl, f1, f5;
  logic wh, be, hi, cp, dy, mu, ch, lng, s28, stb;
  dccfg_mode_e cm;
  int errors, comparisons, al;
  int np[5];
  logic gd, gr;

  dccfg_top #(.P_ACK_CYCLES(16)) dccfg_top_i (
    .I_CORE_CLK(clk), .I_SRST(srst), .I_CMD_VALID(cvl), .I_CMD_MODE(cm),
    .I_CMD_WRITE(cw), .I_CMD_ADDR(ca), .I_CMD_CV(cc), .I_CMD_DATA(cd),
    .I_FN_VALID(fv), .I_FN_ADDR(fa), .I_FN_ID(fid), .I_FN_ON(fon),
    .I_DIR_FWD(fwd), .I_CAM(cam), .O_BUSY(busy), .O_DONE(done),
    .O_REJECT(rej), .O_RD_DATA(rd), .O_ACK_LOAD(ack), .O_HEADLIGHT(hl),
    .O_BACKUP(bl), .O_FUNC1(f1), .O_FUNC5(f5), .O_WHISTLE(wh),
    .O_BELL(be), .O_HISS(hi), .O_COUPLER(cp), .O_DYNAMO(dy), .O_MUTE(mu),
    .O_CHUFF(ch), .O_ACTIVE_ADDR(aa), .O_LONG_ADDR(lng), .O_SPEED28(s28),
    .O_SPEED_TABLE(stb), .O_VSTART(vs), .O_ACCEL(ac), .O_BRAKE(br),
    .O_CON_ACCEL(cac), .O_CON_BRAKE(cbr), .O_CONSIST(cons),
    .O_VOLUME(vol), .O_BG_SOUND(bg));

  dccfg_station dccfg_station_i (
    .clk(clk), .busy(busy), .done(done), .reject(rej), .ack(ack),
    .valid(cvl), .mode(cm), .write(cw), .addr(ca), .cv(cc), .data(cd));

  always #5 clk = ~clk;

  // one-cycle effects are counted so a stuck or doubled pulse shows
  always @(negedge clk) begin
    if (wh === 1'b1) np[0]++;
    if (be === 1'b1) np[1]++;
    if (hi === 1'b1) np[2]++;
    if (cp === 1'b1) np[3]++;
    if (ch === 1'b1) np[4]++;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input dccfg_mode_e m, input logic w,
                     input logic [9:0] n, input logic [7:0] d);
    dccfg_station_i.send(m, w, n, d);
    gd = dccfg_station_i.got_done;
    gr = dccfg_station_i.got_rej;
    al = dccfg_station_i.ack_len;
  endtask

  task automatic fn(input logic [3:0] id, input logic on, input logic f);
    @(negedge clk);
    fid = id;
    fon = on;
    fwd = f;
    fv = 1'b1;
    @(negedge clk);
    fv = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic do_reset();
    int i;
    @(negedge clk);
    srst = 1'b1;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    for (i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
    if (busy !== 1'b0) errors++;
    repeat (2) @(negedge clk);
  endtask

  task automatic stop_test();
    errors += dccfg_station_i.tmo;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    fv = 1'b0;
    fon = 1'b0;
    fwd = 1'b1;
    cam = 1'b0;
    fid = 4'h0;
    fa = 14'h0003;
    errors = 0;
    comparisons = 0;
    do_reset();
    check(aa, 16'h0003);
    check({vs, ac}, 16'h0700);
    check(br, 16'h0000);
    check({lng, s28, stb}, 16'h0002);
    check({cons, vol}, 16'h0080);
    check(bg, 16'h00ff);
    cmd(MD_DIRECT, 1'b0, 10'h003, 8'h00);
    check({gd, rd}, 16'h0100);
    check(16'(al), 16'h0010);
    cmd(MD_DIRECT, 1'b0, 10'h003, 8'h01);
    check({gd, gr, 14'(al)}, 16'h8000);
    cmd(MD_DIRECT, 1'b1, 10'h01d, 8'h12);
    check(16'(al), 16'h0010);
    check({s28, stb}, 16'h0003);
    cmd(MD_DIRECT, 1'b1, 10'h003, 8'hff);
    check(ac, 16'h00ff);
    cmd(MD_DIRECT, 1'b0, 10'h003, 8'hff);
    check({rd, 8'(al)}, 16'hff10);
    for (int s = 0; s < 10; s++) begin
      cmd(MD_REG, 1'b0, 10'(s), 8'h00);
      check(gr, (s == 0 || s == 6 || s > 8));
    end
    cmd(MD_REG, 1'b1, 10'h003, 8'h55);
    check(ac, 16'h0055);
    cmd(MD_REG, 1'b1, 10'h005, 8'h00);
    check({s28, stb}, 16'h0000);
    cmd(MD_ADDR, 1'b1, 10'h01d, 8'h05);
    check({aa, s28}, 16'h000a);
    cmd(MD_ADDR, 1'b1, 10'h001, 8'h03);
    cmd(MD_REG, 1'b1, 10'h005, 8'h02);
    cmd(MD_PAGED, 1'b1, 10'h006, 8'h06);
    cmd(MD_PAGED, 1'b1, 10'h003, 8'h21);
    check(cac, 16'h0021);
    cmd(MD_PAGED, 1'b0, 10'h006, 8'h06);
    check(rd, 16'h0006);
    cmd(MD_PAGED, 1'b1, 10'h005, 8'h00);
    check(gr, 16'h0001);
    cmd(MD_OPS_SHORT, 1'b1, 10'h018, 8'h44);
    check({gd, 8'(al), cbr[6:0]}, 16'h8044);
    check(busy, 16'h0000);
    cmd(MD_OPS_SHORT, 1'b1, 10'h003, 8'h11);
    check({gr, ac}, 16'h0155);
    foreach (np[k]) np[k] = 0;
    for (int k = 0; k < 3; k++) begin
      cmd(MD_OPS_LONG, 1'b1, (k == 0) ? 10'h001 : 10'h010 + 10'(k), 8'h7f);
      check({gr, 8'(al)}, 16'h0100);
    end
    check(aa, 16'h0003);
    cmd(MD_OPS_LONG, 1'b1, 10'h004, 8'h09);
    check({gd, 8'(al), br[6:0]}, 16'h8009);
    cmd(dccfg_mode_e'(3'h6), 1'b1, 10'h004, 8'h01);
    check({gr, br}, 16'h0109);
    fn(FN_LIGHT, 1'b1, 1'b1);
    check({hl, bl}, 16'h0002);
    fn(FN_F1, 1'b1, 1'b0);
    check({hl, bl, f1}, 16'h0003);
    fn(FN_F5, 1'b1, 1'b0);
    fn(FN_F1, 1'b0, 1'b0);
    check({f1, f5}, 16'h0001);
    for (int k = 2; k < 5; k++) fn(4'(k), 1'b1, 1'b1);
    fn(FN_COUPLER, 1'b1, 1'b1);
    check({4'(np[0]), 4'(np[1]), 4'(np[2]), 4'(np[3])}, 16'h1111);
    fn(FN_DYNAMO, 1'b1, 1'b1);
    fn(FN_MUTE, 1'b1, 1'b1);
    check({dy, mu}, 16'h0003);
    @(negedge clk);
    cam = 1'b1;
    repeat (6) @(negedge clk);
    cam = 1'b0;
    check(np[4][15:0], 16'h0001);
    do_reset();
    check({br, cbr}, 16'h0944);
    cmd(MD_DIRECT, 1'b1, 10'h011, 8'h01);
    cmd(MD_DIRECT, 1'b1, 10'h012, 8'h02);
    check(aa, 16'h0003);
    cmd(MD_DIRECT, 1'b1, 10'h01d, 8'h22);
    @(negedge clk);
    check({lng, 1'b0, aa}, 16'h8102);
    stop_test();
  end
endmodule

// [verilog/dccfg_cvstore.sv]
// byte-wide configuration variable store with one-cycle read
`timescale 1ns/1ps
module dccfg_cvstore (
  input wire logic i_clk,
  dccfg_mem_if.mem m
);
  import dccfg_pkg::*;

  typedef struct packed {
    logic [7:0] rdata;
  } dccfg_store_s;

  typedef logic [7:0] dccfg_image_t [NUM_CVS];

  function automatic dccfg_image_t factory_image();
    dccfg_image_t img;
    for (int i = 0; i < NUM_CVS; i++) begin
      img[i] = cv_default(CV_W'(i + 1));
    end
    return img;
  endfunction

  // stands in for flash: the reset never touches it, so programmed
  // values outlive a reset; only the power-up image is factory.
  // loaded by the declaration so the clocked write stays the one writer
  logic [7:0] mem_r [NUM_CVS] = factory_image();
  dccfg_store_s q_r;
  dccfg_store_s q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.rdata = mem_r[m.addr];
  end

  always_ff @(posedge i_clk) begin
    q_r <= q_nxt;
    if (m.we) begin
      mem_r[m.addr] <= m.wdata;
    end
  end

  assign m.rdata = q_r.rdata;

endmodule

// [verilog/dccfg_mem_if.sv]
// port bundle between the command engine and the variable store
`timescale 1ns/1ps
interface dccfg_mem_if;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// [verilog/dccfg_pkg.sv]
// constants, types and factory values for the decoder configuration block
package dccfg_pkg;

  // store geometry
  localparam int NUM_CVS = 256;
  localparam int CV_W = 10;
  localparam int ADDR_W = 14;

  // variable numbers of the configuration store
  localparam logic [9:0] CV_PRIMARY_ADDRESS = 10'h001;
  localparam logic [9:0] CV_VSTART = 10'h002;
  localparam logic [9:0] CV_ACCELERATION_RATE = 10'h003;
  localparam logic [9:0] CV_BRAKING_RATE = 10'h004;
  localparam logic [9:0] CV_SLOT7 = 10'h007;
  localparam logic [9:0] CV_SLOT8 = 10'h008;
  localparam logic [9:0] CV_EXT_ADDR_HI = 10'h011;
  localparam logic [9:0] CV_EXT_ADDR_LO = 10'h012;
  localparam logic [9:0] CV_CONSIST_ADDR = 10'h013;
  localparam logic [9:0] CV_CONSIST_ACCELERATION = 10'h017;
  localparam logic [9:0] CV_CONSIST_BRAKING = 10'h018;
  localparam logic [9:0] CV_DECODER_CONFIGURATION = 10'h01d;
  localparam logic [9:0] CV_VOLUME = 10'h080;
  localparam logic [9:0] CV_BG_SOUND = 10'h081;
  localparam logic [9:0] CV_EXH_SOURCE = 10'h082;
  localparam logic [9:0] CV_LAST = 10'h100;

  // register and paged slot numbers
  localparam logic [9:0] SLOT_FIRST = 10'h001;
  localparam logic [9:0] SLOT_DIRECT_LAST = 10'h004;
  localparam logic [9:0] SLOT_CONFIG = 10'h005;
  localparam logic [9:0] SLOT_PAGE = 10'h006;
  localparam logic [7:0] PAGE_RESET = 8'h01;

  // factory values
  localparam logic [7:0] DEF_ADDRESS = 8'h03;
  localparam logic [7:0] DEF_VSTART = 8'h07;
  localparam logic [7:0] DEF_ACCEL = 8'h00;
  localparam logic [7:0] DEF_BRAKE = 8'h00;
  localparam logic [7:0] DEF_CONSIST = 8'h00;
  localparam logic [7:0] DEF_CONFIG = 8'h02;
  localparam logic [7:0] DEF_VOLUME = 8'h80;
  localparam logic [7:0] DEF_BG_SOUND = 8'hff;
  localparam logic [7:0] DEF_EXH_SOURCE = 8'h01;
  localparam logic [7:0] DEF_OTHER = 8'h00;

  // field positions
  localparam int CFG_DIR_REV = 0;
  localparam int CFG_SPEED28 = 1;
  localparam int CFG_TABLES = 4;
  localparam int CFG_LONG_ADDR = 5;
  localparam int EXH_CAM_BIT = 0;
  localparam int SHORT_ADDR_MSB = 6;
  localparam int EXT_HI_MSB = 5;

  // acknowledge timing
  localparam int CLK_MHZ = 100;
  localparam int ACK_TIME_MS = 50;
  localparam int ACK_CYCLES = ACK_TIME_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 23;

  // function keys
  localparam logic [3:0] FN_LIGHT = 4'h0;
  localparam logic [3:0] FN_F1 = 4'h1;
  localparam logic [3:0] FN_WHISTLE = 4'h2;
  localparam logic [3:0] FN_BELL = 4'h3;
  localparam logic [3:0] FN_HISS = 4'h4;
  localparam logic [3:0] FN_F5 = 4'h5;
  localparam logic [3:0] FN_DYNAMO = 4'h6;
  localparam logic [3:0] FN_COUPLER = 4'h7;
  localparam logic [3:0] FN_MUTE = 4'h8;
  localparam int FN_N = 9;

  // shadow slots held in flops for the running logic
  localparam int SH_N = 13;
  localparam int SH_PRI = 0;
  localparam int SH_VSTART = 1;
  localparam int SH_ACCEL = 2;
  localparam int SH_BRAKE = 3;
  localparam int SH_EXT_HI = 4;
  localparam int SH_EXT_LO = 5;
  localparam int SH_CONSIST = 6;
  localparam int SH_CON_ACC = 7;
  localparam int SH_CON_BRK = 8;
  localparam int SH_CONFIG = 9;
  localparam int SH_VOLUME = 10;
  localparam int SH_BG = 11;
  localparam int SH_EXH = 12;

  typedef enum logic [2:0] {
    ST_LOAD, ST_LCAP, ST_IDLE, ST_CMP, ST_ACK
  } dccfg_state_e;

  typedef enum logic [2:0] {
    MD_ADDR, MD_REG, MD_PAGED, MD_DIRECT, MD_OPS_SHORT, MD_OPS_LONG
  } dccfg_mode_e;

  function automatic logic [9:0] sh_cv(input int i);
    logic [9:0] c;
    c = CV_VOLUME;
    case (i)
      SH_PRI: c = CV_PRIMARY_ADDRESS;
      SH_VSTART: c = CV_VSTART;
      SH_ACCEL: c = CV_ACCELERATION_RATE;
      SH_BRAKE: c = CV_BRAKING_RATE;
      SH_EXT_HI: c = CV_EXT_ADDR_HI;
      SH_EXT_LO: c = CV_EXT_ADDR_LO;
      SH_CONSIST: c = CV_CONSIST_ADDR;
      SH_CON_ACC: c = CV_CONSIST_ACCELERATION;
      SH_CON_BRK: c = CV_CONSIST_BRAKING;
      SH_CONFIG: c = CV_DECODER_CONFIGURATION;
      SH_BG: c = CV_BG_SOUND;
      SH_EXH: c = CV_EXH_SOURCE;
      default: c = CV_VOLUME;
    endcase
    return c;
  endfunction

  // factory content of store word a (variable a+1)
  function automatic logic [7:0] cv_default(input logic [9:0] n);
    logic [7:0] v;
    v = DEF_OTHER;
    case (n)
      CV_PRIMARY_ADDRESS: v = DEF_ADDRESS;
      CV_VSTART: v = DEF_VSTART;
      CV_ACCELERATION_RATE: v = DEF_ACCEL;
      CV_BRAKING_RATE: v = DEF_BRAKE;
      CV_CONSIST_ADDR: v = DEF_CONSIST;
      CV_DECODER_CONFIGURATION: v = DEF_CONFIG;
      CV_VOLUME: v = DEF_VOLUME;
      CV_BG_SOUND: v = DEF_BG_SOUND;
      CV_EXH_SOURCE: v = DEF_EXH_SOURCE;
      default: v = DEF_OTHER;
    endcase
    return v;
  endfunction

endpackage

// [verilog/dccfg_top.sv]
// configuration store, programming command engine and function mapping
`timescale 1ns/1ps

module dccfg_top #(
  parameter int P_ACK_CYCLES = dccfg_pkg::ACK_CYCLES
) (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  // programming command from the packet decoder
  input wire logic I_CMD_VALID,
  input wire dccfg_pkg::dccfg_mode_e I_CMD_MODE,
  input wire logic I_CMD_WRITE,
  input wire logic [dccfg_pkg::ADDR_W-1:0] I_CMD_ADDR,
  input wire logic [dccfg_pkg::CV_W-1:0] I_CMD_CV,
  input wire logic [7:0] I_CMD_DATA,
  // function command and direction
  input wire logic I_FN_VALID,
  input wire logic [dccfg_pkg::ADDR_W-1:0] I_FN_ADDR,
  input wire logic [3:0] I_FN_ID,
  input wire logic I_FN_ON,
  input wire logic I_DIR_FWD,
  // exhaust cam pin
  input wire logic I_CAM,
  // command status
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_REJECT,
  output logic [7:0] O_RD_DATA,
  output logic O_ACK_LOAD,
  // lamps and effects
  output logic O_HEADLIGHT,
  output logic O_BACKUP,
  output logic O_FUNC1,
  output logic O_FUNC5,
  output logic O_WHISTLE,
  output logic O_BELL,
  output logic O_HISS,
  output logic O_COUPLER,
  output logic O_DYNAMO,
  output logic O_MUTE,
  output logic O_CHUFF,
  // running settings
  output logic [dccfg_pkg::ADDR_W-1:0] O_ACTIVE_ADDR,
  output logic O_LONG_ADDR,
  output logic O_SPEED28,
  output logic O_SPEED_TABLE,
  output logic [7:0] O_VSTART,
  output logic [7:0] O_ACCEL,
  output logic [7:0] O_BRAKE,
  output logic [7:0] O_CON_ACCEL,
  output logic [7:0] O_CON_BRAKE,
  output logic [7:0] O_CONSIST,
  output logic [7:0] O_VOLUME,
  output logic [7:0] O_BG_SOUND
);
  import dccfg_pkg::*;

  typedef struct packed {
    dccfg_state_e st;
    logic [3:0] idx;
    logic [SH_N-1:0][7:0] sh;
    logic [7:0] page;
    logic [CNT_W-1:0] cnt;
    logic busy;
    logic ack;
    logic done;
    logic reject;
    logic svc;
    logic [7:0] vdata;
    logic [7:0] rd;
    logic [FN_N-1:0] fn;
    logic [3:0] trig;
    logic hl;
    logic bl;
    logic [ADDR_W-1:0] act;
    logic [2:0] cam;
    logic chuff;
  } dccfg_main_s;

  dccfg_main_s q_r;
  dccfg_main_s q_nxt;
  dccfg_mem_if mif ();
  logic mem_we;
  logic [7:0] mem_addr;
  logic [8:0] tgt;
  logic take;
  logic page_wr;

  function automatic logic is_service(input dccfg_mode_e md);
    return (md != MD_OPS_SHORT) && (md != MD_OPS_LONG);
  endfunction

  function automatic logic [7:0] sh_addr(input int i);
    return 8'(sh_cv(i) - CV_PRIMARY_ADDRESS);
  endfunction

  // {accepted, store word} for a mode and slot or variable number
  function automatic logic [8:0] map_cv(input dccfg_mode_e md,
                                        input logic [9:0] n,
                                        input logic [7:0] page);
    logic [9:0] c;
    logic ok;
    c = n;
    ok = 1'b1;
    unique case (md)
      MD_ADDR: c = CV_PRIMARY_ADDRESS;
      MD_REG: begin
        if (n == SLOT_CONFIG) begin
          c = CV_DECODER_CONFIGURATION;
        end else begin
          ok = (n >= SLOT_FIRST && n <= SLOT_DIRECT_LAST) ||
               n == CV_SLOT7 || n == CV_SLOT8;
        end
      end
      MD_PAGED: begin
        ok = n >= SLOT_FIRST && n <= SLOT_DIRECT_LAST;
        c = 10'({2'h0, page - PAGE_RESET, 2'h0}) + n;
      end
      MD_DIRECT: ok = 1'b1;
      MD_OPS_SHORT: ok = n == CV_CONSIST_ACCELERATION ||
                         n == CV_CONSIST_BRAKING;
      MD_OPS_LONG: ok = n != CV_PRIMARY_ADDRESS && n != CV_EXT_ADDR_HI &&
                        n != CV_EXT_ADDR_LO;
      default: ok = 1'b0;
    endcase
    ok = ok && c >= CV_PRIMARY_ADDRESS && c <= CV_LAST;
    return {ok, 8'(c - CV_PRIMARY_ADDRESS)};
  endfunction

  // one-hot effect trigger for a key, zero for non-trigger keys
  function automatic logic [3:0] trig_slot(input logic [3:0] id);
    logic [3:0] t;
    t = 4'h0;
    case (id)
      FN_WHISTLE: t = 4'h1;
      FN_BELL: t = 4'h2;
      FN_HISS: t = 4'h4;
      FN_COUPLER: t = 4'h8;
      default: t = 4'h0;
    endcase
    return t;
  endfunction

  // main-track commands carry an address; service ones reach any decoder
  // on the programming track
  assign take = q_r.st == ST_IDLE && I_CMD_VALID &&
                (is_service(I_CMD_MODE) || I_CMD_ADDR == q_r.act);
  assign page_wr = I_CMD_MODE == MD_PAGED && I_CMD_CV == SLOT_PAGE;
  assign tgt = map_cv(I_CMD_MODE, I_CMD_CV, q_r.page);

  always_comb begin
    logic ack_go;
    logic fwd;
    ack_go = 1'b0;
    fwd = I_DIR_FWD ^ q_r.sh[SH_CONFIG][CFG_DIR_REV];
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    q_nxt.reject = 1'b0;
    q_nxt.trig = 4'h0;
    mem_we = 1'b0;
    mem_addr = sh_addr(int'(q_r.idx));
    unique case (q_r.st)
      ST_LOAD: q_nxt.st = ST_LCAP;
      ST_LCAP: begin
        q_nxt.sh[q_r.idx] = mif.rdata;
        if (q_r.idx == 4'(SH_N - 1)) begin
          q_nxt.st = ST_IDLE;
        end else begin
          q_nxt.idx = q_r.idx + 4'h1;
          q_nxt.st = ST_LOAD;
        end
      end
      ST_IDLE: begin
        if (take) begin
          q_nxt.svc = is_service(I_CMD_MODE);
          if (page_wr) begin
            q_nxt.done = 1'b1;
            if (I_CMD_WRITE) begin
              q_nxt.page = I_CMD_DATA;
              ack_go = 1'b1;
            end else begin
              q_nxt.rd = q_r.page;
              ack_go = q_r.page == I_CMD_DATA;
            end
          end else if (!tgt[8]) begin
            q_nxt.reject = 1'b1;
          end else if (I_CMD_WRITE) begin
            mem_we = 1'b1;
            mem_addr = tgt[7:0];
            for (int i = 0; i < SH_N; i++) begin
              if (sh_addr(i) == tgt[7:0]) begin
                q_nxt.sh[i] = I_CMD_DATA;
              end
            end
            q_nxt.done = 1'b1;
            ack_go = 1'b1;
          end else begin
            mem_addr = tgt[7:0];
            q_nxt.vdata = I_CMD_DATA;
            q_nxt.st = ST_CMP;
          end
          // the main track has no load sensing, so no acknowledge there
          ack_go = ack_go && q_nxt.svc;
        end
      end
      ST_CMP: begin
        q_nxt.rd = mif.rdata;
        q_nxt.done = 1'b1;
        q_nxt.st = ST_IDLE;
        ack_go = q_r.svc && mif.rdata == q_r.vdata;
      end
      ST_ACK: begin
        if (q_r.cnt == '0) begin
          q_nxt.ack = 1'b0;
          q_nxt.st = ST_IDLE;
        end else begin
          q_nxt.cnt = q_r.cnt - 1'b1;
        end
      end
    endcase
    // motor pulse; its current is set by the bridge, the length here
    if (ack_go) begin
      q_nxt.st = ST_ACK;
      q_nxt.ack = 1'b1;
      q_nxt.cnt = CNT_W'(P_ACK_CYCLES - 1);
    end
    q_nxt.busy = q_nxt.st != ST_IDLE;

    // function keys work in every state, also during a main-track write
    if (I_FN_VALID && I_FN_ADDR == q_r.act && I_FN_ID < 4'(FN_N)) begin
      q_nxt.fn[I_FN_ID] = I_FN_ON;
      if (I_FN_ON && !q_r.fn[I_FN_ID]) begin
        q_nxt.trig = trig_slot(I_FN_ID);
      end
    end
    q_nxt.hl = q_r.fn[FN_LIGHT] & fwd;
    q_nxt.bl = q_r.fn[FN_LIGHT] & ~fwd;
    if (q_r.sh[SH_CONFIG][CFG_LONG_ADDR]) begin
      q_nxt.act = {q_r.sh[SH_EXT_HI][EXT_HI_MSB:0], q_r.sh[SH_EXT_LO]};
    end else begin
      q_nxt.act = {7'h00, q_r.sh[SH_PRI][SHORT_ADDR_MSB:0]};
    end
    q_nxt.cam = {q_r.cam[1:0], I_CAM};
    q_nxt.chuff = q_r.cam[1] & ~q_r.cam[2] &
                  q_r.sh[SH_EXH][EXH_CAM_BIT];
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      q_r <= '0;
      q_r.st <= ST_LOAD;
      q_r.busy <= 1'b1;
      q_r.page <= PAGE_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign mif.we = mem_we;
  assign mif.addr = mem_addr;
  assign mif.wdata = I_CMD_DATA;

  // factory image lives in the store
  dccfg_cvstore u_store (
    .i_clk(I_CORE_CLK),
    .m(mif.mem)
  );

  assign O_BUSY = q_r.busy;
  assign O_DONE = q_r.done;
  assign O_REJECT = q_r.reject;
  assign O_RD_DATA = q_r.rd;
  assign O_ACK_LOAD = q_r.ack;
  assign O_HEADLIGHT = q_r.hl;
  assign O_BACKUP = q_r.bl;
  assign O_FUNC1 = q_r.fn[FN_F1];
  assign O_FUNC5 = q_r.fn[FN_F5];
  assign O_WHISTLE = q_r.trig[0];
  assign O_BELL = q_r.trig[1];
  assign O_HISS = q_r.trig[2];
  assign O_COUPLER = q_r.trig[3];
  assign O_DYNAMO = q_r.fn[FN_DYNAMO];
  assign O_MUTE = q_r.fn[FN_MUTE];
  assign O_CHUFF = q_r.chuff;
  assign O_ACTIVE_ADDR = q_r.act;
  assign O_LONG_ADDR = q_r.sh[SH_CONFIG][CFG_LONG_ADDR];
  assign O_SPEED28 = q_r.sh[SH_CONFIG][CFG_SPEED28];
  assign O_SPEED_TABLE = q_r.sh[SH_CONFIG][CFG_TABLES];
  assign O_VSTART = q_r.sh[SH_VSTART];
  assign O_ACCEL = q_r.sh[SH_ACCEL];
  assign O_BRAKE = q_r.sh[SH_BRAKE];
  assign O_CON_ACCEL = q_r.sh[SH_CON_ACC];
  assign O_CON_BRAKE = q_r.sh[SH_CON_BRK];
  assign O_CONSIST = q_r.sh[SH_CONSIST];
  assign O_VOLUME = q_r.sh[SH_VOLUME];
  assign O_BG_SOUND = q_r.sh[SH_BG];

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);

  ack_len_a: assert property ($rose(q_r.ack) |-> q_r.ack[*8])
    else $error("acknowledge pulse shorter than expected");
  // a refused request gets its pulse and nothing else; a later command
  // may follow back to back and raise the load, so only its own answer
  reject_noack_a: assert property (take && !page_wr && !tgt[8]
    |=> q_r.reject && !q_r.ack && !q_r.done)
    else $error("acknowledge after a refused request");
  ops_protect_a: assert property (take &&
    I_CMD_MODE == MD_OPS_LONG &&
    (I_CMD_CV == CV_PRIMARY_ADDRESS || I_CMD_CV == CV_EXT_ADDR_HI ||
     I_CMD_CV == CV_EXT_ADDR_LO) |=> q_r.reject && !q_r.done)
    else $error("protected address variable not refused");
  short_form_a: assert property (take &&
    I_CMD_MODE == MD_OPS_SHORT &&
    I_CMD_CV != CV_CONSIST_ACCELERATION && I_CMD_CV != CV_CONSIST_BRAKING
    |=> q_r.reject)
    else $error("short form accepted a wrong variable");
  addr_mode_a: assert property (take && I_CMD_MODE == MD_ADDR &&
    I_CMD_WRITE |=> q_r.sh[SH_PRI] == $past(I_CMD_DATA) && q_r.ack)
    else $error("address mode write lost");
  reg_mode_a: assert property (take && I_CMD_MODE == MD_REG &&
    (I_CMD_CV == SLOT_PAGE || I_CMD_CV > CV_SLOT8 ||
     I_CMD_CV < SLOT_FIRST) |=> q_r.reject)
    else $error("register mode reached an illegal slot");
  cfg_bits_a: assert property (take && I_CMD_MODE == MD_DIRECT &&
    I_CMD_WRITE && I_CMD_CV == CV_DECODER_CONFIGURATION &&
    I_CMD_DATA == 8'h12 |=> O_SPEED28 && O_SPEED_TABLE)
    else $error("config byte bits not applied");
  headlight_a: assert property (q_r.fn[FN_LIGHT] &&
    (I_DIR_FWD ^ q_r.sh[SH_CONFIG][CFG_DIR_REV])
    |=> O_HEADLIGHT && !O_BACKUP)
    else $error("headlight not following direction");
  mute_key_a: assert property (I_FN_VALID && I_FN_ADDR == q_r.act &&
    I_FN_ID == FN_MUTE |=> O_MUTE == $past(I_FN_ON))
    else $error("mute key not applied");

  svc_write_c: cover property (take && I_CMD_WRITE && q_nxt.svc
    ##1 q_r.ack);
  ops_write_c: cover property (take && I_CMD_MODE == MD_OPS_LONG &&
    I_CMD_WRITE ##1 q_r.done);
  verify_hit_c: cover property (take && !I_CMD_WRITE ##2 q_r.ack);
  paged_c: cover property (take && page_wr ##1 q_r.ack);

endmodule
